//--- design/ald_pkg_sync.sv
// Shared constants for arbitration-loss detection and a two-stage synchroniser.

package ald_pkg;
   // =====================================================================
   // Status byte layout, reset values and address width
   // =====================================================================
   localparam int unsigned ALD_STATUS_W = 8;
   localparam int unsigned ALD_LOST_BIT = 3;
   localparam int unsigned ALD_SAM_BIT = 4;
   localparam logic ALD_LOST_RESET = 1'h0;
   localparam logic ALD_SAM_RESET = 1'h0;
   localparam logic [ALD_STATUS_W-1:0] ALD_STATUS_ZERO = 8'h00;
   localparam int unsigned ALD_ADDR_W = 7;

   // =====================================================================
   // Start-command tracking states
   // =====================================================================
   typedef enum logic {
      ALD_START_IDLE,
      ALD_START_ARMED
   } ald_start_t;
endpackage

// Two flip-flop level synchroniser; only the second stage is visible.
module ald_sync (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Asynchronous level in, synchronised level out
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_q <= 1'h0;
         sync_q <= 1'h0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

//--- design/ald_top.sv
// Arbitration-loss and second-address match flag logic of the bus master.

// Functional notes
// RQ1: In master transmit, own SDA differing from pin at SCL rise sets lost flag.
// RQ2: With select zero, internal SCL high at pin SCL fall sets lost flag.
// RQ3: With select one, foreign SDA low before ours after start sets flag.
// RQ4: Data register write in transmit or read in receive clears lost flag.
// RQ5: Lost flag is status bit 3, resets to 0, writes only clear it.
// RQ6: Second-address match flag clears by zero write after reading it as one.
// RQ7: Start condition clears match flag; it stays clear in master mode.
// RQ8: Slave receive, format select zero, first frame matching address sets flag.
// RQ9: Lost flag holds until a clearing event and makes the master let go.
module ald_top
   import ald_pkg::*;
(
   // System clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Link clock, the SCL pin used as a clock
   input wire logic scl_link_in,
   // Bus pins as seen on the wire
   input wire logic scl_pin_in,
   input wire logic sda_pin_in,
   // Internal line values this interface drives
   input wire logic scl_int_in,
   input wire logic sda_int_in,
   // Mode and configuration
   input wire logic master_in,
   input wire logic transmit_in,
   input wire logic arb_lost_condition_select_in,
   input wire logic second_addr_format_sel_in,
   input wire logic [ALD_ADDR_W-1:0] second_slave_addr_reg_in,
   // Software commands and accesses
   input wire logic start_cmd_in,
   input wire logic bus_data_reg_wr_in,
   input wire logic bus_data_reg_rd_in,
   input wire logic status_rd_in,
   input wire logic status_wr_in,
   input wire logic [ALD_STATUS_W-1:0] status_wdata_in,
   // Received first frame after a start
   input wire logic frame_done_in,
   input wire logic [ALD_ADDR_W-1:0] rx_addr_in,
   // Flags and status
   output logic arb_lost_flag_out,
   output logic second_addr_match_flag_out,
   output logic [ALD_STATUS_W-1:0] status_out,
   output logic release_bus_out,
   output logic start_det_out
);

   // =====================================================================
   // Link domain: capture SDA at each SCL rise
   // =====================================================================
   // The captured level is held a full SCL period and only read by the
   // system domain after the toggle has been synchronised, so the word
   // never changes while it is being used.
   logic sda_cap_q;
   logic rise_tgl_q;

   always_ff @(posedge scl_link_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sda_cap_q <= 1'h0;
         rise_tgl_q <= 1'h0;
      end else begin
         sda_cap_q <= sda_pin_in;
         rise_tgl_q <= ~rise_tgl_q;
      end
   end

   // =====================================================================
   // Synchronisers into the system domain
   // =====================================================================
   logic rise_tgl_s;
   logic scl_s;
   logic sda_s;

   ald_sync u_sync_tgl (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .async_in(rise_tgl_q),
      .sync_out(rise_tgl_s)
   );

   ald_sync u_sync_scl (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .async_in(scl_pin_in),
      .sync_out(scl_s)
   );

   ald_sync u_sync_sda (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .async_in(sda_pin_in),
      .sync_out(sda_s)
   );

   // =====================================================================
   // Edge detection on synchronised levels
   // =====================================================================
   logic rise_tgl_d_q;
   logic scl_d_q;
   logic sda_d_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      // The delayed levels reset to what the synchronisers show in reset,
      // so the idle-high lines give no false fall or start after release.
      if (!nrst_in) begin
         rise_tgl_d_q <= 1'h0;
         scl_d_q <= 1'h0;
         sda_d_q <= 1'h0;
      end else begin
         rise_tgl_d_q <= rise_tgl_s;
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end

   logic scl_rise_evt;
   logic scl_fall_evt;
   logic start_evt;

   assign scl_rise_evt = rise_tgl_s ^ rise_tgl_d_q;
   assign scl_fall_evt = scl_d_q & ~scl_s;
   assign start_evt = scl_s & scl_d_q & sda_d_q & ~sda_s;
   assign start_det_out = start_evt;

   // =====================================================================
   // Start-command tracking
   // =====================================================================
   // Armed by the start command; disarmed once this interface pulls SDA
   // low itself, after which a low SDA is ours and no longer foreign.
   ald_start_t start_state_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         start_state_q <= ALD_START_IDLE;
      end else begin
         case (start_state_q)
            ALD_START_IDLE: begin
               if (start_cmd_in && master_in && transmit_in) begin
                  start_state_q <= ALD_START_ARMED;
               end
            end
            ALD_START_ARMED: begin
               if (!sda_int_in || !master_in || !transmit_in) begin
                  start_state_q <= ALD_START_IDLE;
               end
            end
            default: begin
               start_state_q <= ALD_START_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // Arbitration-lost setting conditions
   // =====================================================================
   logic set_mismatch;
   logic set_scl_high;
   logic set_foreign_low;
   logic lost_set;

   // RQ1: SDA disagreement at rise.
   assign set_mismatch = scl_rise_evt & master_in & transmit_in
      & (sda_cap_q != sda_int_in);
   // RQ2: internal SCL high.
   assign set_scl_high = ~arb_lost_condition_select_in & master_in
      & scl_fall_evt & scl_int_in;
   // RQ3: foreign SDA low.
   assign set_foreign_low = arb_lost_condition_select_in
      & (start_state_q == ALD_START_ARMED) & master_in & transmit_in
      & sda_int_in & ~sda_s;
   assign lost_set = set_mismatch | set_scl_high | set_foreign_low;

   // =====================================================================
   // Arbitration-lost flag
   // =====================================================================
   logic lost_q;
   logic lost_clr;
   logic lost_wr_clr;

   // RQ4: data register access clears.
   assign lost_clr = (bus_data_reg_wr_in & transmit_in)
      | (bus_data_reg_rd_in & ~transmit_in);
   // RQ5: status writes may only clear.
   assign lost_wr_clr = status_wr_in & ~status_wdata_in[ALD_LOST_BIT];

   // RQ9: sticky until cleared; a set in the clearing cycle wins.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lost_q <= ALD_LOST_RESET;
      end else if (lost_set) begin
         lost_q <= 1'h1;
      end else if (lost_clr || lost_wr_clr) begin
         lost_q <= 1'h0;
      end
   end

   // =====================================================================
   // Second-address match flag
   // =====================================================================
   logic sam_q;
   logic sam_read_q;
   logic sam_set;
   logic sam_wr_clr;

   // RQ8: first frame matches second address.
   assign sam_set = frame_done_in & ~master_in & ~transmit_in
      & ~second_addr_format_sel_in
      & (rx_addr_in == second_slave_addr_reg_in);
   // RQ6: zero write honoured only after reading one.
   assign sam_wr_clr = status_wr_in & sam_read_q
      & ~status_wdata_in[ALD_SAM_BIT];

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sam_read_q <= 1'h0;
      end else if (status_rd_in && sam_q) begin
         sam_read_q <= 1'h1;
      end else if (status_wr_in || !sam_q) begin
         sam_read_q <= 1'h0;
      end
   end

   // RQ7: start or master mode forces clear.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sam_q <= ALD_SAM_RESET;
      end else if (master_in || start_evt) begin
         sam_q <= 1'h0;
      end else if (sam_set) begin
         sam_q <= 1'h1;
      end else if (sam_wr_clr) begin
         sam_q <= 1'h0;
      end
   end

   // =====================================================================
   // Outputs
   // =====================================================================
   always_comb begin
      status_out = ALD_STATUS_ZERO;
      status_out[ALD_LOST_BIT] = lost_q;
      status_out[ALD_SAM_BIT] = sam_q;
   end

   assign arb_lost_flag_out = lost_q;
   assign second_addr_match_flag_out = sam_q;
   // RQ9: lost master releases bus.
   assign release_bus_out = lost_q & master_in;

endmodule

//--- bench/ald_peer.sv
// Model of another bus party that clocks frames and pulls SDA low.
module ald_peer (
   // Frame and data control from the bench
   input wire logic run_in,
   input wire logic sda_low_in,
   // Open-drain levels, 1 while released
   output logic scl_out,
   output logic sda_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // =============================================
   // Link clock and data line
   // =============================================
   initial begin
      scl_out = 1'h1;
      #37;
      // SCL stands high between frames, as its pull-up leaves it.
      forever #80 scl_out = run_in ? !scl_out : 1'h1;
   end
   // foreign SDA low
   // Data only moves while SCL is low or the bus is idle; the pull-up
   // holds the line high until the first change arrives.
   initial begin
      sda_out = 1'h1;
      forever begin
         @(sda_low_in or scl_out or run_in);
         if (!scl_out || !run_in) begin
            sda_out = !sda_low_in;
         end
      end
   end
endmodule

//--- bench/ald_assertions.sv
// Checker for the lost and match flag outputs.
module ald_checker
   import ald_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Mode and accesses
   input wire logic master_in,
   input wire logic transmit_in,
   input wire logic bus_data_reg_wr_in,
   input wire logic bus_data_reg_rd_in,
   input wire logic status_wr_in,
   // Flags
   input wire logic arb_lost_flag_out,
   input wire logic second_addr_match_flag_out,
   input wire logic [ALD_STATUS_W-1:0] status_out,
   input wire logic release_bus_out,
   input wire logic start_det_out
);
   timeunit 1ns;
   timeprecision 100ps;
   wire lf = arb_lost_flag_out;
   wire mf = second_addr_match_flag_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // =============================================
   // Properties
   // =============================================
   property p_map; status_out == {3'h0, mf, lf, 3'h0}; endproperty
   a_map: assert property (p_map)
      else $error("status byte layout wrong");
   property p_wclr; bus_data_reg_wr_in && transmit_in && !master_in
      |=> !lf; endproperty
   a_wclr: assert property (p_wclr)
      else $error("lost flag not cleared by write");
   property p_rclr; bus_data_reg_rd_in && !transmit_in && !master_in
      |=> !lf; endproperty
   a_rclr: assert property (p_rclr)
      else $error("lost flag not cleared by read");
   property p_hold; lf && !bus_data_reg_wr_in && !bus_data_reg_rd_in
      && !status_wr_in |=> lf; endproperty
   a_hold: assert property (p_hold)
      else $error("lost flag dropped");
   property p_rel; release_bus_out == (lf && master_in); endproperty
   a_rel: assert property (p_rel)
      else $error("bus release wrong");
   property p_nset; (!master_in)[*5] |-> !$rose(lf); endproperty
   a_nset: assert property (p_nset)
      else $error("lost flag set outside master");
   property p_mst; master_in || start_det_out |=> !mf; endproperty
   a_mst: assert property (p_mst)
      else $error("match flag not cleared");
   property p_mhold; mf && !master_in && !start_det_out && !status_wr_in
      |=> mf; endproperty
   a_mhold: assert property (p_mhold)
      else $error("match flag dropped");
   c_lost: cover property ($rose(lf));
   c_mset: cover property ($rose(mf));
   c_mclr: cover property ($fell(mf));
endmodule

bind ald_top ald_checker u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .master_in(master_in), .transmit_in(transmit_in),
   .bus_data_reg_wr_in(bus_data_reg_wr_in),
   .bus_data_reg_rd_in(bus_data_reg_rd_in), .status_wr_in(status_wr_in),
   .arb_lost_flag_out(arb_lost_flag_out), .status_out(status_out),
   .second_addr_match_flag_out(second_addr_match_flag_out),
   .release_bus_out(release_bus_out), .start_det_out(start_det_out));

//--- bench/testbench.sv
// Directed bench for the arbitration-loss and match flag block.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ald_pkg::*;
   logic clk_in, nrst_in, scl_int, sda_int, mst, tx, sel, fmt_sel, stc;
   logic wr, rd, srd, swr, fd, run, sda_low, scl_p, sda_p, rel;
   logic lost, match, sdet;
   logic [ALD_STATUS_W-1:0] wd, st;
   int fail_count = 0;
   int n_checks = 0;
   int n_start = 0;
   int cyc = 0;
   wire scl_w = scl_p & scl_int;
   wire sda_w = sda_p & sda_int;
   ald_peer u_peer (.run_in(run), .sda_low_in(sda_low), .scl_out(scl_p),
      .sda_out(sda_p));
   ald_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .scl_link_in(scl_w),
      .scl_pin_in(scl_w), .sda_pin_in(sda_w), .scl_int_in(scl_int),
      .sda_int_in(sda_int), .master_in(mst), .transmit_in(tx),
      .arb_lost_condition_select_in(sel),
      .second_addr_format_sel_in(fmt_sel),
      .second_slave_addr_reg_in(7'h35), .start_cmd_in(stc),
      .bus_data_reg_wr_in(wr), .bus_data_reg_rd_in(rd), .status_rd_in(srd),
      .status_wr_in(swr), .status_wdata_in(wd), .frame_done_in(fd),
      .rx_addr_in(wd[6:0]), .arb_lost_flag_out(lost),
      .second_addr_match_flag_out(match), .status_out(st),
      .release_bus_out(rel), .start_det_out(sdet));
   // =============================================
   // Clock, timeout and tasks
   // =============================================
   initial begin
      clk_in = 1'h0;
      forever #5 clk_in = !clk_in;
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   // Start pulses seen on the bus, compared once at the end.
   always @(posedge clk_in) begin
      if (sdet === 1'h1) begin
         n_start <= n_start + 1;
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Access pulses {wr, rd, srd, swr, fd, stc}; d is write data or address.
   task automatic acc(input logic [5:0] k, input logic [7:0] d);
      @(posedge clk_in);
      {wr, rd, srd, swr, fd, stc} <= k;
      wd <= d;
      @(posedge clk_in);
      {wr, rd, srd, swr, fd, stc} <= 6'h00;
      @(posedge clk_in);
      #1;
   endtask
   // Mode {master, transmit, select, peer pulls SDA}; waits out the sync.
   task automatic md(input logic [3:0] m);
      @(posedge clk_in);
      {mst, tx, sel, sda_low} <= m;
      repeat (8) @(posedge clk_in);
      #1;
   endtask
   task automatic fr();
      @(posedge clk_in);
      run <= 1'h1;
      repeat (40) @(posedge clk_in);
      run <= 1'h0;
      repeat (30) @(posedge clk_in);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // =============================================
   // Scenarios
   // =============================================
   initial begin
      {nrst_in, stc, wr, rd, srd, swr, fd, run, sda_low} = 9'h000;
      {mst, tx, sel, fmt_sel, scl_int, sda_int} = 6'h03;
      wd = 8'h00;
      repeat (6) @(posedge clk_in);
      nrst_in <= 1'h1;
      @(posedge clk_in);
      #1;
      chk(st, 8'h00);
      acc(6'h04, 8'hff);
      chk(st, 8'h00);
      for (int s = 1; s >= 0; s--) begin
         md({3'h6, 1'h0} | {2'h0, s[0], 1'h0});
         fr();
         chk(st, s ? 8'h00 : 8'h08);
      end
      chk({7'h00, rel}, 8'h01);
      fr();
      chk(st, 8'h08);
      md(4'h4);
      acc(6'h20, 8'h00);
      chk(st, 8'h00);
      md(4'hc);
      @(posedge clk_in) scl_int <= 1'h0;
      repeat (6) @(posedge clk_in);
      scl_int <= 1'h1;
      md(4'hc);
      chk(st, 8'h00);
      md(4'hb);
      fr();
      chk(st, 8'h00);
      md(4'hf);
      fr();
      chk(st, 8'h08);
      chk({6'h00, match, lost}, 8'h01);
      md(4'h0);
      acc(6'h10, 8'h00);
      chk(st, 8'h00);
      md(4'he);
      acc(6'h01, 8'h00);
      @(posedge clk_in) sda_int <= 1'h0;
      repeat (3) @(posedge clk_in);
      sda_int <= 1'h1;
      md(4'hf);
      chk(st, 8'h00);
      md(4'he);
      acc(6'h01, 8'h00);
      chk(st, 8'h00);
      md(4'hf);
      chk(st, 8'h08);
      md(4'h4);
      acc(6'h20, 8'h00);
      md(4'h0);
      acc(6'h02, 8'h34);
      chk(st, 8'h00);
      @(posedge clk_in) fmt_sel <= 1'h1;
      acc(6'h02, 8'h35);
      chk(st, 8'h00);
      @(posedge clk_in) fmt_sel <= 1'h0;
      acc(6'h02, 8'h35);
      chk(st, 8'h10);
      chk({6'h00, match, lost}, 8'h02);
      acc(6'h04, 8'h00);
      chk(st, 8'h10);
      acc(6'h08, 8'h00);
      acc(6'h04, 8'h00);
      chk(st, 8'h00);
      acc(6'h02, 8'h35);
      md(4'h8);
      chk(st, 8'h00);
      md(4'h0);
      acc(6'h02, 8'h35);
      md(4'h1);
      chk(st, 8'h00);
      md(4'h0);
      chk(n_start[7:0], 8'h05);
      summarize();
   end
endmodule
